/* hdl/lapd_message_buffer_port.sv */
// apb slave giving access to message buffer one
// assumes the hdlc engine of the selected controller
// drives the rx and tx strobes synchronous to pclk
//
// Chosen here: the APB slave port.
module lapd_message_buffer_port
    import lapd_buf_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq,
    output logic      [SEL_W-1:0]  hdlc_sel,
    output logic                   tx_start,
    output logic      [CNT_W-1:0]  tx_len,
    input  wire logic              tx_rd_req,
    output logic      [BYTE_W-1:0] tx_rd_data,
    input  wire logic [2:0]        tx_done,
    input  wire logic              rx_wr_valid,
    input  wire logic [BYTE_W-1:0] rx_wr_data,
    input  wire logic [2:0]        rx_eom
);
    // map an index onto a controller number
    function automatic logic [SEL_W-1:0] find_ctrl(
        input logic [IDX_W-1:0] idx,
        input logic             rx
    );
        logic [SEL_W-1:0] c;
        c = SEL_NONE;
        if (idx == (rx ? IDX_RX_CNT1 : IDX_TX_CNT1))
            c = 2'h0;
        if (idx == (rx ? IDX_RX_CNT2 : IDX_TX_CNT2))
            c = 2'h1;
        if (idx == (rx ? IDX_RX_CNT3 : IDX_TX_CNT3))
            c = 2'h2;
        return c;
    endfunction : find_ctrl

    logic [DATA_W-1:0] prdata_ff;    // read data
    logic              pready_ff;    // one wait state
    logic              pslverr_ff;   // unmapped access
    logic              irq_ff;       // interrupt level
    logic [SEL_W-1:0]  sel_ff;       // controller select
    logic              tx_start_ff;  // hand-off pulse
    logic [CNT_W-1:0]  tx_len_ff;    // queued length
    logic [BYTE_W-1:0] tx_rd_ff;     // byte to engine
    logic [INT_W-1:0]  sts_ff;       // sticky events
    logic [INT_W-1:0]  msk_ff;       // event mask
    logic [2:0]        free_ff;      // tx buffer free
    logic [2:0]        owner_ff;     // rx message held
    logic [CNT_W-1:0]  tx_cnt_ff [NUM_CTRL];
    logic [CNT_W-1:0]  rx_cnt_ff [NUM_CTRL];
    logic [DATA_W-1:0] nxt_prdata;   // read mux

    // bus decode
    logic [IDX_W-1:0]  idx;
    logic              setup_acc;
    logic              acc_done;
    logic [SEL_W-1:0]  tx_c;
    logic [SEL_W-1:0]  rx_c;
    logic              hit_port;
    logic              mapped;
    logic              wr_done;
    logic              rd_done;
    // buffer ownership of the selected controller
    logic              sel_free;
    logic              sel_owner;
    logic              sw_wr;
    logic              sw_rd;
    logic              handoff;
    logic              release_rx;
    logic              rx_take;
    logic              hdlc_rd;
    logic              sel_txd;
    logic              sel_eom;
    logic [PTR_W-1:0]  sw_ptr;
    logic [PTR_W-1:0]  hw_ptr;
    logic [BYTE_W-1:0] sw_rdata;
    logic [BYTE_W-1:0] hw_rdata;

    assign idx       = paddr[ADDR_W-1:2];
    assign setup_acc = psel && penable && !pready_ff;
    assign acc_done  = psel && penable && pready_ff;
    assign tx_c      = find_ctrl(idx, 1'b0);
    assign rx_c      = find_ctrl(idx, 1'b1);
    assign hit_port  = (idx == IDX_MSG_PORT);
    // unaligned or unknown addresses answer with an error
    assign mapped    = (paddr[1:0] == 2'h0) &&
                       (hit_port || idx == IDX_SELECT ||
                        idx == IDX_INT_STS || idx == IDX_INT_MSK ||
                        tx_c != SEL_NONE || rx_c != SEL_NONE);
    // only the low byte lane carries register data
    assign wr_done   = acc_done && pwrite && mapped && pstrb[0];
    assign rd_done   = acc_done && !pwrite && mapped;

    assign sel_free  = free_ff[sel_ff];
    assign sel_owner = owner_ff[sel_ff];
    assign sel_txd   = tx_done[sel_ff];
    assign sel_eom   = rx_eom[sel_ff];
    // port write gating
    // a held rx message must not be overwritten
    assign sw_wr      = wr_done && hit_port && sel_free && !sel_owner;
    assign sw_rd      = rd_done && hit_port && sel_owner;
    assign handoff    = wr_done && tx_c == sel_ff && sel_free;
    assign release_rx = wr_done && rx_c == sel_ff && pwdata[FLAG_BIT];
    // engine fills only an unclaimed buffer
    assign rx_take    = rx_wr_valid && !sel_owner;
    assign hdlc_rd    = tx_rd_req && !sel_free;

    byte_pointer #(
        .DEPTH (BUF_DEPTH),
        .W     (PTR_W)
    ) u_sw_ptr (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (handoff || sel_txd || sel_eom || release_rx),
        .inc     (sw_wr || sw_rd),
        .ptr_ff  (sw_ptr)
    );

    byte_pointer #(
        .DEPTH (BUF_DEPTH),
        .W     (PTR_W)
    ) u_hw_ptr (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (handoff || sel_txd || sel_eom),
        .inc     (hdlc_rd || rx_take),
        .ptr_ff  (hw_ptr)
    );

    // shared buffer, engine write beats software write
    msg_buffer_ram #(
        .DEPTH (BUF_DEPTH),
        .AW    (PTR_W),
        .DW    (BYTE_W)
    ) u_ram (
        .pclk    (pclk),
        .we      (rx_take || sw_wr),
        .waddr   (rx_take ? hw_ptr : sw_ptr),
        .wdata   (rx_take ? rx_wr_data : pwdata[BYTE_W-1:0]),
        .raddr_a (sw_ptr),
        .rdata_a (sw_rdata),
        .raddr_b (hw_ptr),
        .rdata_b (hw_rdata)
    );

    // apb handshake, answer one cycle into access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff  <= setup_acc;
            pslverr_ff <= setup_acc && !mapped;
        end
    end

    // read mux
    always_comb
    begin
        nxt_prdata = '0;
        if (hit_port)
        begin
            nxt_prdata[BYTE_W-1:0] = sel_owner ? sw_rdata : PORT_RST;
        end
        else if (idx == IDX_SELECT)
            nxt_prdata[SEL_W-1:0] = sel_ff;
        else if (idx == IDX_INT_STS)
            nxt_prdata[INT_W-1:0] = sts_ff;
        else if (idx == IDX_INT_MSK)
            nxt_prdata[INT_W-1:0] = msk_ff;
        else if (tx_c != SEL_NONE)
        begin
            nxt_prdata[FLAG_BIT]    = free_ff[tx_c];
            nxt_prdata[CNT_W-1:0]   = tx_cnt_ff[tx_c];
        end
        else if (rx_c != SEL_NONE)
        begin
            nxt_prdata[FLAG_BIT]    = owner_ff[rx_c];
            nxt_prdata[CNT_W-1:0]   = rx_cnt_ff[rx_c];
        end
    end

    // read data stands only during the answer cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_ff <= '0;
        else if (setup_acc && !pwrite && mapped)
            prdata_ff <= nxt_prdata;
        else
            prdata_ff <= '0;
    end

    // controller select and mask
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_ff <= SEL_RST;
            msk_ff <= MASK_RST;
        end
        else if (wr_done)
        begin
            if (idx == IDX_SELECT && pwdata[SEL_W-1:0] != SEL_NONE)
                sel_ff <= pwdata[SEL_W-1:0];
            if (idx == IDX_INT_MSK)
                msk_ff <= pwdata[INT_W-1:0];
        end
    end

    // per controller flags and counts
    for (genvar i = 0; i < NUM_CTRL; i++)
    begin : g_ctrl
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                free_ff[i]   <= 1'b1;
                owner_ff[i]  <= 1'b0;
                tx_cnt_ff[i] <= '0;
                rx_cnt_ff[i] <= '0;
            end
            else
            begin
                if (tx_done[i])
                    free_ff[i] <= 1'b1;
                else if (handoff && sel_ff == SEL_W'(i))
                    free_ff[i] <= 1'b0;
                if (handoff && sel_ff == SEL_W'(i))
                    tx_cnt_ff[i] <= pwdata[CNT_W-1:0];
                // end of message wins over release
                if (rx_eom[i])
                    owner_ff[i] <= 1'b1;
                else if (release_rx && sel_ff == SEL_W'(i))
                    owner_ff[i] <= 1'b0;
                if (rx_eom[i] && sel_ff == SEL_W'(i))
                    rx_cnt_ff[i] <= hw_ptr;
            end
        end
    end

    // engine side outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_start_ff <= 1'b0;
            tx_len_ff   <= '0;
            tx_rd_ff    <= '0;
        end
        else
        begin
            tx_start_ff <= handoff;
            if (handoff)
                tx_len_ff <= pwdata[CNT_W-1:0];
            if (hdlc_rd)
                tx_rd_ff <= hw_rdata;
        end
    end

    // sticky events, write one clears, set wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sts_ff <= '0;
            irq_ff <= 1'b0;
        end
        else
        begin
            sts_ff[INT_TX_END] <= sel_txd ||
                (sts_ff[INT_TX_END] &&
                 !(wr_done && idx == IDX_INT_STS && pwdata[INT_TX_END]));
            sts_ff[INT_RX_EOM] <= sel_eom ||
                (sts_ff[INT_RX_EOM] &&
                 !(wr_done && idx == IDX_INT_STS && pwdata[INT_RX_EOM]));
            irq_ff <= |(sts_ff & msk_ff);
        end
    end

    assign prdata     = prdata_ff;
    assign pready     = pready_ff;
    assign pslverr    = pslverr_ff;
    assign irq        = irq_ff;
    assign hdlc_sel   = sel_ff;
    assign tx_start   = tx_start_ff;
    assign tx_len     = tx_len_ff;
    assign tx_rd_data = tx_rd_ff;

    // checks on the port behaviour
    AST_ONE_WAIT: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup_acc |=> pready_ff ##1 !pready_ff)
        else $error("apb answer not after one wait");

    AST_SELECT: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_done && idx == IDX_SELECT && pwdata[1:0] != 2'h3)
        |=> sel_ff == $past(pwdata[1:0]))
        else $error("controller select not taken");

    AST_FREE_SET: assert property (
        @(posedge pclk) disable iff (!presetn)
        sel_txd |=> sel_free && sts_ff[INT_TX_END])
        else $error("free flag not set after send");

    AST_HANDOFF: assert property (
        @(posedge pclk) disable iff (!presetn)
        handoff |=> tx_start_ff && !sel_free && hw_ptr == 7'h00)
        else $error("queued message not started");

    AST_NO_READBACK: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup_acc && !pwrite && hit_port && !sel_owner)
        |=> prdata_ff == 32'h0000_0000)
        else $error("sent data readable");

    AST_OWNER: assert property (
        @(posedge pclk) disable iff (!presetn)
        (sel_eom && !tx_done[sel_ff]) |=> sel_owner ##1 irq_ff || !msk_ff[1])
        else $error("owner flag or irq missing");

    AST_RX_DATA: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup_acc && !pwrite && hit_port && sel_owner && !rx_take)
        |=> prdata_ff[7:0] == $past(sw_rdata))
        else $error("wrong received byte");

    AST_ADVANCE: assert property (
        @(posedge pclk) disable iff (!presetn)
        (sw_rd && !sel_txd && !sel_eom && sw_ptr < 7'd95)
        |=> sw_ptr == $past(sw_ptr) + 7'd1)
        else $error("pointer did not advance");

    AST_RESTART: assert property (
        @(posedge pclk) disable iff (!presetn)
        (sel_txd || sel_eom || release_rx) |=> sw_ptr == 7'h00)
        else $error("pointer not restarted");
endmodule : lapd_message_buffer_port

/* hdl/lapd_buf_pkg.sv */
// package of constants for the message buffer port block
// assumes one APB clock, word aligned 32-bit accesses
package lapd_buf_pkg;
    // bus geometry
    localparam int ADDR_W    = 13;
    localparam int DATA_W    = 32;
    localparam int IDX_W     = 11;
    // buffer geometry
    localparam int BUF_DEPTH = 96;
    localparam int PTR_W     = 7;
    localparam int BYTE_W    = 8;
    // controller select
    localparam int NUM_CTRL  = 3;
    localparam int SEL_W     = 2;
    localparam logic [SEL_W-1:0] SEL_NONE = 2'h3;
    localparam logic [SEL_W-1:0] SEL_RST  = 2'h0;
    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_MSG_PORT = 11'h700;
    localparam logic [IDX_W-1:0] IDX_SELECT   = 11'h11B;
    localparam logic [IDX_W-1:0] IDX_TX_CNT1  = 11'h114;
    localparam logic [IDX_W-1:0] IDX_TX_CNT2  = 11'h144;
    localparam logic [IDX_W-1:0] IDX_TX_CNT3  = 11'h154;
    localparam logic [IDX_W-1:0] IDX_RX_CNT1  = 11'h115;
    localparam logic [IDX_W-1:0] IDX_RX_CNT2  = 11'h145;
    localparam logic [IDX_W-1:0] IDX_RX_CNT3  = 11'h155;
    localparam logic [IDX_W-1:0] IDX_INT_STS  = 11'h120;
    localparam logic [IDX_W-1:0] IDX_INT_MSK  = 11'h121;
    // field positions in the byte count registers
    localparam int FLAG_BIT  = 7;
    localparam int CNT_W     = 7;
    // interrupt status layout
    localparam int INT_W      = 2;
    localparam int INT_TX_END = 0;
    localparam int INT_RX_EOM = 1;
    // reset values
    localparam logic [INT_W-1:0]  MASK_RST = 2'h0;
    localparam logic [BYTE_W-1:0] PORT_RST = 8'h00;
endpackage : lapd_buf_pkg

/* hdl/msg_buffer_ram.sv */
// byte array holding one message buffer
// one write port, two combinational read ports
module msg_buffer_ram #(
    parameter int DEPTH = 96,
    parameter int AW    = 7,
    parameter int DW    = 8
) (
    input  wire logic          pclk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr_a,
    output logic      [DW-1:0] rdata_a,
    input  wire logic [AW-1:0] raddr_b,
    output logic      [DW-1:0] rdata_b
);
    // storage, no reset so it maps onto plain memory
    logic [DW-1:0] mem [DEPTH];

    // write port, out of range addresses dropped
    always_ff @(posedge pclk)
    begin
        if (we && (32'(waddr) < DEPTH))
        begin
            mem[waddr] <= wdata;
        end
    end

    // read ports
    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];
endmodule : msg_buffer_ram

/* hdl/byte_pointer.sv */
// auto incrementing byte pointer for the buffer
// clear wins over increment, wraps after last byte
module byte_pointer #(
    parameter int DEPTH = 96,
    parameter int W     = 7
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         clr,
    input  wire logic         inc,
    output logic      [W-1:0] ptr_ff
);
    // last legal location
    localparam logic [W-1:0] LAST = W'(DEPTH - 1);

    // pointer register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ptr_ff <= '0;
        end
        else if (clr)
        begin
            ptr_ff <= '0;
        end
        else if (inc)
        begin
            // wrap keeps an overlong message inside
            ptr_ff <= (ptr_ff == LAST) ? '0 : ptr_ff + W'(1);
        end
    end
endmodule : byte_pointer

/* test/hdlc_engine_model.sv */
// behavioural model of the three hdlc engines behind the buffer port
// assumes it shares pclk with the block and drives on rising edges
module hdlc_engine_model
    import lapd_buf_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              tx_start,
    input  wire logic [CNT_W-1:0]  tx_len,
    input  wire logic [SEL_W-1:0]  hdlc_sel,
    input  wire logic [BYTE_W-1:0] tx_rd_data,
    output logic                   tx_rd_req,
    output logic      [2:0]        tx_done,
    output logic                   rx_wr_valid,
    output logic      [BYTE_W-1:0] rx_wr_data,
    output logic      [2:0]        rx_eom
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [BYTE_W-1:0] sent_q[$]; // bytes pulled out of the buffer
    int                gap = 0;   // idle cycles per byte, slow engine
    // engines idle until handed a message
    initial
    begin
        tx_rd_req   = 1'b0;
        tx_done     = 3'h0;
        rx_wr_valid = 1'b0;
        rx_wr_data  = 8'h00;
        rx_eom      = 3'h0;
    end
    always @(posedge pclk)
    begin
        if (tx_start === 1'b1)
        begin
            repeat (int'(tx_len))
            begin
                repeat (gap) @(posedge pclk);
                tx_rd_req <= 1'b1;
                @(posedge pclk);
                tx_rd_req <= 1'b0;
                @(posedge pclk);
                sent_q.push_back(tx_rd_data);
            end
            tx_done[hdlc_sel] <= 1'b1;
            @(posedge pclk);
            tx_done <= 3'h0;
        end
    end
    // write n received bytes then flag end of message
    task automatic send_rx(input logic [1:0] sel, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge pclk);
            rx_wr_valid <= 1'b1;
            rx_wr_data  <= 8'h5A ^ 8'(i);
        end
        @(posedge pclk);
        rx_wr_valid <= 1'b0;
        // stale data must not look valid, so it is inverted
        rx_wr_data  <= ~rx_wr_data;
        rx_eom[sel] <= 1'b1;
        @(posedge pclk);
        rx_eom <= 3'h0;
    endtask : send_rx
endmodule : hdlc_engine_model

/* test/lapd_message_buffer_port_test.sv */
// self-checking bench for the message buffer port
// assumes the engine model answers on the far side
module lapd_message_buffer_port_test import lapd_buf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic [SEL_W-1:0]  hdlc_sel;
    logic              tx_start, tx_rd_req, rx_wr_valid;
    logic [CNT_W-1:0]  tx_len;
    logic [BYTE_W-1:0] tx_rd_data, rx_wr_data;
    logic [2:0]        tx_done, rx_eom;
    int                n_mismatch = 0;  // failed comparisons
    int                check_count = 0; // all comparisons
    int                cycles = 0;      // timeout counter
    logic [IDX_W-1:0]  tx_idx[3] = '{IDX_TX_CNT1, IDX_TX_CNT2, IDX_TX_CNT3};
    logic [IDX_W-1:0]  rx_idx[3] = '{IDX_RX_CNT1, IDX_RX_CNT2, IDX_RX_CNT3};
    lapd_message_buffer_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .hdlc_sel(hdlc_sel), .tx_start(tx_start),
        .tx_len(tx_len), .tx_rd_req(tx_rd_req), .tx_rd_data(tx_rd_data), .tx_done(tx_done),
        .rx_wr_valid(rx_wr_valid), .rx_wr_data(rx_wr_data), .rx_eom(rx_eom));
    hdlc_engine_model u_eng (.pclk(pclk), .tx_start(tx_start), .tx_len(tx_len), .hdlc_sel(hdlc_sel),
        .tx_rd_data(tx_rd_data), .tx_rd_req(tx_rd_req), .tx_done(tx_done),
        .rx_wr_valid(rx_wr_valid), .rx_wr_data(rx_wr_data), .rx_eom(rx_eom));
    // 10 MHz clock
    always #50 pclk = ~pclk;
    // a hang ends the run as a failure
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        if (n_mismatch == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // one apb transfer; an idle edge first keeps drives unique per step
    task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] wd,
                       output logic [DATA_W-1:0] rd, output logic err);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // wait as long as the answer takes, the bench timeout guards a hang
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] wd);
        logic [DATA_W-1:0] rd;
        logic              err;
        apb(1'b1, idx, wd, rd, err);
    endtask : wr
    task automatic rdchk(input string what, input logic [IDX_W-1:0] idx, input logic [31:0] m,
                         input logic [31:0] exp);
        logic [DATA_W-1:0] rd;
        logic              err;
        apb(1'b0, idx, 8'h00, rd, err);
        check(what, exp, rd & m);
    endtask : rdchk
    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge pclk);
        check("irq", 32'(exp), 32'(irq));
    endtask : irq_chk
    task automatic t_reset;
        rdchk("select", IDX_SELECT, 32'hFF, 32'h0);
        rdchk("tx free", IDX_TX_CNT1, 32'h80, 32'h80);
        rdchk("rx owner", IDX_RX_CNT1, 32'h80, 32'h0);
        rdchk("mask", IDX_INT_MSK, 32'hFF, 32'h0);
        rdchk("port", IDX_MSG_PORT, 32'hFFFFFFFF, 32'h0);
    endtask : t_reset
    task automatic t_tx(input int sel, input int n);
        logic [DATA_W-1:0] rd;
        logic              err;
        int                k;
        u_eng.gap = (n < 8) ? 6 : 0;
        wr(IDX_INT_MSK, 8'h01);
        wr(IDX_SELECT, 8'(sel));
        // the select register updates on the completion edge, look one edge later
        @(posedge pclk);
        check("hdlc_sel", 32'(sel), 32'(hdlc_sel));
        rdchk("tx free", tx_idx[sel], 32'h80, 32'h80);
        for (int i = 0; i < n; i++)
            wr(IDX_MSG_PORT, 8'hC0 + 8'(i));
        wr(tx_idx[sel], 8'(n));
        rdchk("tx busy", tx_idx[sel], 32'h80, 32'h0);
        k = 0;
        do
        begin
            apb(1'b0, tx_idx[sel], 8'h00, rd, err);
            k++;
        end
        while (rd[7] !== 1'b1 && k < 300);
        check("tx freed", 32'h80, rd & 32'h80);
        check("sent count", 32'(n), 32'(u_eng.sent_q.size()));
        foreach (u_eng.sent_q[i])
            check("sent byte", 8'(8'hC0 + 8'(i)), u_eng.sent_q[i]);
        u_eng.sent_q.delete();
        rdchk("port after tx", IDX_MSG_PORT, 32'hFF, 32'h0);
        irq_chk(1'b1);
        wr(IDX_INT_STS, 8'h01);
        irq_chk(1'b0);
    endtask : t_tx
    task automatic t_rx(input int sel, input int n);
        wr(IDX_SELECT, 8'(sel));
        wr(IDX_INT_MSK, 8'h00);
        u_eng.send_rx(2'(sel), n);
        // the engine pointer wraps after the last location, so a full buffer counts as zero
        rdchk("rx count", rx_idx[sel], 32'hFF, 32'h80 | 32'(n % BUF_DEPTH));
        irq_chk(1'b0);
        wr(IDX_INT_MSK, 8'h02);
        irq_chk(1'b1);
        for (int i = 0; i < n; i++)
            rdchk("rx byte", IDX_MSG_PORT, 32'hFF, 8'h5A ^ 8'(i));
        wr(rx_idx[sel], 8'h80);
        rdchk("rx released", rx_idx[sel], 32'h80, 32'h0);
        wr(IDX_INT_STS, 8'h02);
        irq_chk(1'b0);
    endtask : t_rx
    task automatic t_err;
        logic [DATA_W-1:0] rd;
        logic              err;
        apb(1'b0, 11'h001, 8'h00, rd, err);
        check("pslverr", 32'h1, 32'(err));
        wr(IDX_SELECT, 8'h03);
        @(posedge pclk);
        check("hdlc_sel kept", 32'h2, 32'(hdlc_sel));
    endtask : t_err
    // reset for three cycles, then the scenarios in turn
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_tx(0, 96);
        t_tx(1, 1);
        t_rx(2, 96);
        t_rx(0, 3);
        t_tx(2, 5);
        t_err();
        report_and_stop();
    end
endmodule : lapd_message_buffer_port_test
